/* cdba_defines.svh */
// Constants for the change driven broadcast aggregator: register map, field
// positions, limits, reset values and timing.
// Assumes inclusion by bare name from each design file that needs it.
`ifndef CDBA_DEFINES_SVH
`define CDBA_DEFINES_SVH

// ==========================================================================
// Register byte offsets.
// ==========================================================================
`define CDBA_OFS_STATUS    8'h00
`define CDBA_OFS_DELIVERY  8'h04
`define CDBA_OFS_INTERVAL  8'h08
`define CDBA_OFS_UDP_PORT  8'h0C
`define CDBA_OFS_RSRC_ADDR 8'h10
`define CDBA_OFS_BLK_CFG   8'h14
`define CDBA_OFS_BCAST_ID  8'h18
`define CDBA_OFS_RX_JOBS   8'h1C

// ==========================================================================
// Field positions.
// ==========================================================================
`define CDBA_ST_TIMER_BIT  11
`define CDBA_ST_PROG_BIT   12
`define CDBA_ST_ERR_BIT    13
`define CDBA_CFG_VALID_BIT 31
`define CDBA_MARK_BIT      31

// ==========================================================================
// Limits.
// ==========================================================================
`define CDBA_BUF_MAX       11'd1472
`define CDBA_ITEM_OVH      11'd4
`define CDBA_BLK_MAX_BYTES 10'd110
`define CDBA_BLK_MAX_ITEMS 9'd272
`define CDBA_WORD_MAX_CNT  9'd55
`define CDBA_PACK_MAX_B    10'd34
`define CDBA_RSRC_MAX      32'h0000_FFFF
`define CDBA_INTERVAL_MAX  10'd655
`define CDBA_RX_JOBS_MAX   7'd64
`define CDBA_SEND_JOBS     4
`define CDBA_BLKS_PER_JOB  8
`define CDBA_SLOTS         32

// ==========================================================================
// Reset values.
// ==========================================================================
`define CDBA_RST_DELIVERY  16'h0064
`define CDBA_RST_INTERVAL  10'h000
`define CDBA_RST_UDP_PORT  16'h05E2

// ==========================================================================
// Timing.
// ==========================================================================
`define CDBA_CLK_MHZ       200
`define CDBA_TICK_MS       1
`define CDBA_MS_PER_S      10'd1000

`endif

/* cdba_pkg.sv */
// Types shared by the broadcast aggregator modules.
// Assumes nothing of its surroundings.
`default_nettype none
package cdba_pkg;

  // Memory type of a sending block; only the first three report changes.
  typedef enum logic [1:0] {
    CDBA_MT_WORD   = 2'h0,
    CDBA_MT_PACKED = 2'h1,
    CDBA_MT_BYTE   = 2'h2,
    CDBA_MT_OTHER  = 2'h3
  } cdba_mem_type;

endpackage

`default_nettype wire

/* cdba_buf2.sv */
// Two-entry valid/ready buffer in the aggregator's output stream.
// Assumes one clock and a synchronous active high reset.
`timescale 1ns/100ps
`default_nettype none

module cdba_buf2 #(
  parameter int W = 32
) (
  input  wire logic         sys_clk_in,
  input  wire logic         rst_in,
  input  wire logic         in_valid_in,
  output logic              in_ready_out,
  input  wire logic [W-1:0] in_data_in,
  output logic              out_valid_out,
  input  wire logic         out_ready_in,
  output logic      [W-1:0] out_data_out
);

  logic [W-1:0] mem_q [2];
  logic         rd_q;
  logic         wr_q;
  logic [1:0]   cnt_q;
  logic         push;
  logic         pop;

  assign in_ready_out  = (cnt_q != 2'h2);
  assign out_valid_out = (cnt_q != 2'h0);
  assign out_data_out  = mem_q[rd_q];
  assign push          = in_valid_in & in_ready_out;
  assign pop           = out_valid_out & out_ready_in;

  always_ff @(posedge sys_clk_in) begin
    if (push) begin
      mem_q[wr_q] <= in_data_in;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      rd_q  <= 1'b0;
      wr_q  <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      if (push) begin
        wr_q <= ~wr_q;
      end
      if (pop) begin
        rd_q <= ~rd_q;
      end
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end

endmodule

`default_nettype wire

/* cdba_top.sv */
// Change driven broadcast aggregator: scans the leading word of 32 blocks and
// queues changes into frames closed on a full buffer or an expired timer.
// Assumes one AHB-Lite master, a same-cycle memory scan and a frame sender.
//
// Implementation choices: the register addresses and register access over AHB-Lite.
`timescale 1ns/100ps
`default_nettype none
`include "cdba_defines.svh"

// Overview of operation
// - Reject remote source start address above 65535.
// - Send jobs run once configured, no trigger.
// - Program mode suspends all send activity.
// - First change starts timer; buffer holds 1472.
// - Send when full or delivery timer expires.
// - Send on configured port; receivers listen there.
// - At most 4 send, 64 receive jobs.
// - Eight blocks per job, change-reporting types only.
// - Block limit 110 bytes and 272 items.
// - Reject words over 55, packed over 34 bytes.
// - Only leading word watched; whole block queued.
// - Byte size from count and type units.
// - After send, timer zero until new data.
// - Nonzero interval queues all blocks each interval.
module cdba_top #(
  parameter int TICK_CYCLES = `CDBA_CLK_MHZ * 1000 * `CDBA_TICK_MS
) (
  input  wire logic        sys_clk_in,
  input  wire logic        rst_in,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  input  wire logic        prog_mode_in,
  output logic      [4:0]  scan_slot_out,
  input  wire logic [15:0] scan_word_in,
  output logic             item_valid_out,
  input  wire logic        item_ready_in,
  output logic      [31:0] item_data_out,
  output logic      [15:0] bcast_port_out
);

  function automatic logic [9:0] blk_bytes(input logic [1:0] t, input logic [8:0] c);
    unique case (cdba_pkg::cdba_mem_type'(t))
      cdba_pkg::CDBA_MT_WORD:   blk_bytes = {c, 1'b0};
      cdba_pkg::CDBA_MT_PACKED: blk_bytes = {4'h0, 6'((c + 9'd7) >> 3)};
      default:                  blk_bytes = {1'b0, c};
    endcase
  endfunction

  function automatic logic blk_ok(input logic [1:0] t, input logic [8:0] c);
    logic [9:0] b;
    b = blk_bytes(t, c);
    blk_ok = (cdba_pkg::cdba_mem_type'(t) != cdba_pkg::CDBA_MT_OTHER)
           && (c <= `CDBA_BLK_MAX_ITEMS) && (b <= `CDBA_BLK_MAX_BYTES)
           && !(cdba_pkg::cdba_mem_type'(t) == cdba_pkg::CDBA_MT_WORD
                && c > `CDBA_WORD_MAX_CNT)
           && !(cdba_pkg::cdba_mem_type'(t) == cdba_pkg::CDBA_MT_PACKED
                && b > `CDBA_PACK_MAX_B);
  endfunction

  logic [2:0]  prog_sync_q;
  logic        prog_q;
  logic [7:0]  addr_q;
  logic        wr_q;
  logic [31:0] rdata_d;
  logic [31:0] rdata_q;
  logic [15:0] delivery_q;
  logic [9:0]  interval_q;
  logic [15:0] port_q;
  logic [31:0] rsrc_q;
  logic [31:0] cfg_last_q;
  logic [7:0]  bid_q [`CDBA_SEND_JOBS];
  logic [6:0]  rx_jobs_q;
  logic        err_q;
  logic        blk_vld_q  [`CDBA_SLOTS];
  logic [6:0]  blk_size_q [`CDBA_SLOTS];
  logic [15:0] prev_q     [`CDBA_SLOTS];
  logic [31:0] force_q;
  logic [4:0]  slot_q;
  logic [10:0] fill_q;
  logic        run_q;
  logic [15:0] dly_q;
  logic [31:0] div_q;
  logic        ms_tick;
  logic [9:0]  ms_cnt_q;
  logic [9:0]  sec_cnt_q;
  logic        ivl_tick;
  logic        wr_en;
  logic        bad_wr;
  logic        changed;
  logic [10:0] need;
  logic        need_flush;
  logic        push;
  logic        push_mark;
  logic        push_item;
  logic [31:0] push_data;
  logic        buf_ready;
  logic        buf_valid;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_q;
  assign bcast_port_out = port_q;
  // ========================================================================
  // Program mode pin synchroniser.
  // ========================================================================
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      prog_sync_q <= 3'h0;
      prog_q      <= 1'b0;
    end else begin
      prog_sync_q <= {prog_sync_q[1:0], prog_mode_in};
      if (prog_sync_q[1] == prog_sync_q[2]) begin
        prog_q <= prog_sync_q[2];
      end
    end
  end

  // ========================================================================
  // AHB-Lite slave: read data is fetched in the address phase.
  // ========================================================================
  always_comb begin
    unique case (haddr[7:0])
      `CDBA_OFS_STATUS:    rdata_d = {18'h0_0000, err_q, prog_q, run_q, fill_q};
      `CDBA_OFS_DELIVERY:  rdata_d = {16'h0000, delivery_q};
      `CDBA_OFS_INTERVAL:  rdata_d = {22'h00_0000, interval_q};
      `CDBA_OFS_UDP_PORT:  rdata_d = {16'h0000, port_q};
      `CDBA_OFS_RSRC_ADDR: rdata_d = rsrc_q;
      `CDBA_OFS_BLK_CFG:   rdata_d = cfg_last_q;
      `CDBA_OFS_BCAST_ID:  rdata_d = {bid_q[3], bid_q[2], bid_q[1], bid_q[0]};
      `CDBA_OFS_RX_JOBS:   rdata_d = {25'h000_0000, rx_jobs_q};
      default:             rdata_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      addr_q  <= 8'h00;
      wr_q    <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else if (hready) begin
      wr_q   <= hsel & htrans[1] & hwrite;
      addr_q <= haddr[7:0];
      if (hsel & htrans[1] & ~hwrite) begin
        rdata_q <= rdata_d;
      end
    end
  end
  assign wr_en  = wr_q;
  assign bad_wr = wr_en && (
      (addr_q == `CDBA_OFS_RSRC_ADDR && hwdata > `CDBA_RSRC_MAX) ||
      (addr_q == `CDBA_OFS_INTERVAL && hwdata[9:0] > `CDBA_INTERVAL_MAX) ||
      (addr_q == `CDBA_OFS_RX_JOBS && hwdata[6:0] > `CDBA_RX_JOBS_MAX) ||
      (addr_q == `CDBA_OFS_BLK_CFG && hwdata[`CDBA_CFG_VALID_BIT]
       && !blk_ok(hwdata[6:5], hwdata[15:7])));
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      delivery_q <= `CDBA_RST_DELIVERY;
      interval_q <= `CDBA_RST_INTERVAL;
      port_q     <= `CDBA_RST_UDP_PORT;
      rsrc_q     <= 32'h0000_0000;
      cfg_last_q <= 32'h0000_0000;
      rx_jobs_q  <= 7'h00;
      err_q      <= 1'b0;
      for (int j = 0; j < `CDBA_SEND_JOBS; j++) begin
        bid_q[j] <= 8'h00;
      end
    end else begin
      if (bad_wr) begin
        err_q <= 1'b1;
      end else if (wr_en && addr_q == `CDBA_OFS_STATUS && hwdata[`CDBA_ST_ERR_BIT]) begin
        err_q <= 1'b0;
      end
      if (wr_en && !bad_wr) begin
        unique case (addr_q)
          `CDBA_OFS_DELIVERY:  delivery_q <= hwdata[15:0];
          `CDBA_OFS_INTERVAL:  interval_q <= hwdata[9:0];
          `CDBA_OFS_UDP_PORT:  port_q <= hwdata[15:0];
          `CDBA_OFS_RSRC_ADDR: rsrc_q <= hwdata;
          `CDBA_OFS_BLK_CFG:   cfg_last_q <= hwdata;
          `CDBA_OFS_BCAST_ID:  bid_q[hwdata[1:0]] <= hwdata[15:8];
          `CDBA_OFS_RX_JOBS:   rx_jobs_q <= hwdata[6:0];
          default:             ;
        endcase
      end
    end
  end
  // Block table: 4 jobs of 8 slots each, slot = job * 8 + block.
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      for (int s = 0; s < `CDBA_SLOTS; s++) begin
        blk_vld_q[s]  <= 1'b0;
        blk_size_q[s] <= 7'h00;
      end
    end else if (wr_en && !bad_wr && addr_q == `CDBA_OFS_BLK_CFG) begin
      blk_vld_q[hwdata[4:0]]  <= hwdata[`CDBA_CFG_VALID_BIT];
      blk_size_q[hwdata[4:0]] <= 7'(blk_bytes(hwdata[6:5], hwdata[15:7]));
    end
  end

  // ========================================================================
  // Millisecond and interval timers.
  // ========================================================================
  assign ms_tick  = !prog_q && (div_q == 32'(TICK_CYCLES - 1));
  assign ivl_tick = ms_tick && (interval_q != 10'h000) && (ms_cnt_q == `CDBA_MS_PER_S - 10'd1)
                    && (sec_cnt_q == interval_q - 10'd1);
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      div_q     <= 32'h0000_0000;
      ms_cnt_q  <= 10'h000;
      sec_cnt_q <= 10'h000;
    end else if (!prog_q) begin
      div_q <= ms_tick ? 32'h0000_0000 : div_q + 32'h0000_0001;
      if (ms_tick) begin
        ms_cnt_q <= (ms_cnt_q == `CDBA_MS_PER_S - 10'd1) ? 10'h000 : ms_cnt_q + 10'd1;
        if (ms_cnt_q == `CDBA_MS_PER_S - 10'd1) begin
          sec_cnt_q <= (ivl_tick || interval_q == 10'h000) ? 10'h000 : sec_cnt_q + 10'd1;
        end
      end
    end
  end

  // ========================================================================
  // Scan, change detection and buffer accounting.
  // ========================================================================
  assign scan_slot_out = slot_q;
  assign changed    = blk_vld_q[slot_q] && (scan_word_in != prev_q[slot_q] || force_q[slot_q]);
  assign need       = {4'h0, blk_size_q[slot_q]} + `CDBA_ITEM_OVH;
  assign need_flush = (fill_q != 11'h000) && ((run_q && dly_q >= delivery_q)
                      || (changed && fill_q + need > `CDBA_BUF_MAX)
                      || fill_q == `CDBA_BUF_MAX);
  assign push       = !prog_q && buf_ready && (need_flush || changed);
  assign push_mark  = push && need_flush;
  assign push_item  = push && !need_flush;
  assign push_data  = need_flush ? {1'b1, 20'h0_0000, fill_q}
                                 : {1'b0, slot_q, blk_size_q[slot_q], 3'h0, scan_word_in};
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      slot_q <= 5'h00;
    end else if (!prog_q && buf_ready && !need_flush) begin
      slot_q <= slot_q + 5'h01;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      for (int s = 0; s < `CDBA_SLOTS; s++) begin
        prev_q[s] <= 16'h0000;
      end
    end else if (push_item || (!prog_q && buf_ready && !need_flush && !changed)) begin
      prev_q[slot_q] <= scan_word_in;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      force_q <= 32'h0000_0000;
    end else if (ivl_tick) begin
      force_q <= 32'hFFFF_FFFF;
    end else if (push_item) begin
      force_q[slot_q] <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      fill_q <= 11'h000;
      run_q  <= 1'b0;
      dly_q  <= 16'h0000;
    end else if (push_mark) begin
      fill_q <= 11'h000;
      run_q  <= 1'b0;
      dly_q  <= 16'h0000;
    end else begin
      if (push_item) begin
        fill_q <= fill_q + need;
        run_q  <= 1'b1;
      end
      if (run_q && ms_tick && dly_q != 16'hFFFF) begin
        dly_q <= dly_q + 16'h0001;
      end
    end
  end

  cdba_buf2 #(.W(32)) u_buf (
    .sys_clk_in    (sys_clk_in),
    .rst_in        (rst_in),
    .in_valid_in   (push),
    .in_ready_out  (buf_ready),
    .in_data_in    (push_data),
    .out_valid_out (buf_valid),
    .out_ready_in  (item_ready_in & ~prog_q),
    .out_data_out  (item_data_out)
  );
  assign item_valid_out = buf_valid & ~prog_q;

  // ========================================================================
  // Assertions.
  // ========================================================================
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  a_prog_no_push: assert property (prog_q |-> !push && !item_valid_out)
    else $error("push or output during program mode");
  a_rsrc_reject: assert property (wr_en && addr_q == `CDBA_OFS_RSRC_ADDR
    && hwdata > `CDBA_RSRC_MAX |=> rsrc_q == $past(rsrc_q) && err_q)
    else $error("oversize remote source address accepted");
  a_timer_clear: assert property (push_mark |=> !run_q && dly_q == 16'h0000
    && fill_q == 11'h000) else $error("timer not cleared after send");
  a_timer_start: assert property (push_item && fill_q == 11'h000 |=> run_q
    && fill_q == $past(need)) else $error("first item did not start timer");
  a_fill_bound: assert property (fill_q <= `CDBA_BUF_MAX)
    else $error("buffer fill above limit");
  a_flush_expired: assert property (!prog_q && buf_ready && fill_q != 11'h000
    && run_q && dly_q >= delivery_q |-> push_mark) else $error("expired timer not flushed");
  a_item_size: assert property (push_item |-> push_data[25:19] <= 7'(`CDBA_BLK_MAX_BYTES))
    else $error("item larger than block limit");
  a_force_all: assert property (ivl_tick |=> force_q == 32'hFFFF_FFFF)
    else $error("interval did not force all blocks");
  a_change_push: assert property (!prog_q && buf_ready && !need_flush && blk_vld_q[slot_q]
    && scan_word_in != prev_q[slot_q] |-> push_item) else $error("change not queued");
  a_cfg_reject: assert property (wr_en && addr_q == `CDBA_OFS_BLK_CFG
    && hwdata[`CDBA_CFG_VALID_BIT] && hwdata[6:5] == 2'h3 |=> cfg_last_q == $past(cfg_last_q))
    else $error("non change-reporting type accepted");

endmodule

`default_nettype wire

/* cdba_far_end.sv */
// Far-side model: controller memory that answers the slot scan, and a frame
// receiver that drains the item stream.
// Assumes the testbench writes mem directly and drives stall_in.
`timescale 1ns/100ps
`default_nettype none

module cdba_far_end #(
  parameter logic [15:0] LISTEN_PORT = 16'h1234
) (
  input  wire logic        sys_clk_in,
  input  wire logic        rst_in,
  input  wire logic [4:0]  slot_in,
  output logic      [15:0] word_out,
  input  wire logic        valid_in,
  output logic             ready_out,
  input  wire logic [31:0] data_in,
  input  wire logic [15:0] port_in,
  input  wire logic        stall_in,
  output logic      [15:0] n_items_out,
  output logic      [15:0] n_marks_out,
  output logic      [31:0] last_item_out,
  output logic      [31:0] last_mark_out
);
  logic [15:0] mem [32];

  initial begin
    foreach (mem[i]) mem[i] = 16'h0000;
  end

  assign word_out  = mem[slot_in];
  assign ready_out = ~stall_in;

  // A receiver takes every word but only counts words sent on the port that it listens on.
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      n_items_out   <= 16'h0000;
      n_marks_out   <= 16'h0000;
      last_item_out <= 32'h0000_0000;
      last_mark_out <= 32'h0000_0000;
    end else if (valid_in && ready_out && port_in == LISTEN_PORT) begin
      if (data_in[31]) begin
        n_marks_out   <= n_marks_out + 16'h0001;
        last_mark_out <= data_in;
      end else begin
        n_items_out   <= n_items_out + 16'h0001;
        last_item_out <= data_in;
      end
    end
  end
endmodule

`default_nettype wire

/* tb.sv */
// Testbench for the broadcast aggregator: register access over AHB-Lite,
// configuration limits and the change-driven item stream.
// Assumes cdba_top, cdba_far_end and the shared constants header.
`timescale 1ns/100ps
`default_nettype none
`include "cdba_defines.svh"

module tb;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0]  htrans = 2'b00;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic        prog = 1'b0;
  logic        stall = 1'b0;
  logic        hreadyout, hresp, item_valid, item_ready;
  logic [31:0] hrdata, item_data, rd, last_item, last_mark;
  logic [15:0] port, word, n_items, n_marks;
  logic [4:0]  slot;
  int          fail_count = 0;
  int          n_tests = 0;
  logic [7:0]  ta [11] = '{`CDBA_OFS_RSRC_ADDR, `CDBA_OFS_RSRC_ADDR, `CDBA_OFS_BLK_CFG,
    `CDBA_OFS_BLK_CFG, `CDBA_OFS_BLK_CFG, `CDBA_OFS_BLK_CFG, `CDBA_OFS_BLK_CFG,
    `CDBA_OFS_BLK_CFG, `CDBA_OFS_BLK_CFG, `CDBA_OFS_RX_JOBS, `CDBA_OFS_INTERVAL};
  logic [31:0] td [11] = '{32'h0001_0000, 32'h0000_FFFF, 32'h8000_00FF, 32'h8000_1B9F,
    32'h8000_1C1F, 32'h8000_883F, 32'h8000_88BF, 32'h8000_37DF, 32'h8000_375F,
    32'h0000_0041, 32'h0000_0290};
  logic        te [11] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1};

  always #2.5 sys_clk = ~sys_clk;

  cdba_top #(.TICK_CYCLES(10)) dut (
    .sys_clk_in(sys_clk), .rst_in(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .prog_mode_in(prog),
    .scan_slot_out(slot), .scan_word_in(word), .item_valid_out(item_valid),
    .item_ready_in(item_ready), .item_data_out(item_data), .bcast_port_out(port)
  );

  cdba_far_end far (
    .sys_clk_in(sys_clk), .rst_in(rst), .slot_in(slot), .word_out(word),
    .valid_in(item_valid), .ready_out(item_ready), .data_in(item_data), .port_in(port),
    .stall_in(stall), .n_items_out(n_items), .n_marks_out(n_marks),
    .last_item_out(last_item), .last_mark_out(last_mark)
  );

  // ==========================================================================
  // Shared tasks.
  // ==========================================================================
  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  task automatic wait_ready();
    int k;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (hreadyout !== 1'b1 && k < 50);
    if (hreadyout !== 1'b1) begin
      fail_count++;
      $display("CHECK FAILED at %0t: bus never ready", $time);
      summarize();
    end
  endtask

  // Holds each phase until hready is seen high; read data is taken there.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] r);
    @(posedge sys_clk);
    hsel   <= 1'b1;
    haddr  <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= wr;
    wait_ready();
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_ready();
    r = hrdata;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                      input string s);
    logic [31:0] r;
    bus(1'b0, a, 32'h0000_0000, r);
    check(r & m, e, s);
  endtask

  task automatic errchk(input logic [7:0] a, input logic [31:0] d, input logic e);
    bus(1'b1, `CDBA_OFS_STATUS, 32'h0000_2000, rd);
    bus(1'b1, a, d, rd);
    rchk(`CDBA_OFS_STATUS, 32'h0000_2000, {18'h0_0000, e, 13'h0000}, "reject flag");
  endtask

  task automatic wait_marks(input int n, input int lim);
    int k;
    k = 0;
    while (n_marks < n && k < lim) begin
      @(posedge sys_clk);
      k++;
    end
    if (n_marks < n) begin
      fail_count++;
      $display("CHECK FAILED at %0t: no frame end seen", $time);
      summarize();
    end
  endtask

  // ==========================================================================
  // Main sequence.
  // ==========================================================================
  initial begin
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    rchk(`CDBA_OFS_DELIVERY, 32'h0000_FFFF, 32'h0000_0064, "delivery reset");
    rchk(`CDBA_OFS_INTERVAL, 32'h0000_03FF, 32'h0000_0000, "interval reset");
    rchk(`CDBA_OFS_UDP_PORT, 32'h0000_FFFF, 32'h0000_05E2, "port reset");
    rchk(8'h40, 32'hFFFF_FFFF, 32'h0000_0000, "unmapped read");
    check({16'h0000, port}, 32'h0000_05E2, "port pin reset");
    bus(1'b1, `CDBA_OFS_UDP_PORT, 32'h0000_1234, rd);
    rchk(`CDBA_OFS_UDP_PORT, 32'h0000_FFFF, 32'h0000_1234, "port write");
    check({16'h0000, port}, 32'h0000_1234, "port pin");
    check({31'h0000_0000, hresp}, 32'h0000_0000, "okay response");
    for (int j = 0; j < 4; j++) begin
      bus(1'b1, `CDBA_OFS_BCAST_ID, {16'h0000, 8'(8'h11 * (j + 1)), 6'h00, 2'(j)}, rd);
    end
    rchk(`CDBA_OFS_BCAST_ID, 32'hFFFF_FFFF, 32'h4433_2211, "broadcast ids");
    $display("test registers done");

    for (int i = 0; i < 11; i++) begin
      errchk(ta[i], td[i], te[i]);
    end
    rchk(`CDBA_OFS_BLK_CFG, 32'hFFFF_FFFF, 32'h8000_375F, "last accepted block");
    rchk(`CDBA_OFS_RSRC_ADDR, 32'hFFFF_FFFF, 32'h0000_FFFF, "remote source kept");
    $display("test limits done");

    bus(1'b1, `CDBA_OFS_DELIVERY, 32'h0000_0002, rd);
    bus(1'b1, `CDBA_OFS_BLK_CFG, 32'h8000_0183, rd);
    far.mem[3] <= 16'hABCD;
    repeat (10) @(posedge sys_clk);
    check({16'h0000, n_marks}, 32'h0000_0000, "early send");
    wait_marks(1, 200);
    check(last_item, {1'b0, 5'h03, 7'h06, 3'h0, 16'hABCD}, "item");
    check(last_mark, 32'h8000_000A, "frame bytes");
    rchk(`CDBA_OFS_STATUS, 32'h0000_0FFF, 32'h0000_0000, "timer idle");
    repeat (100) @(posedge sys_clk);
    check({16'h0000, n_items}, 32'h0000_0001, "no change");
    $display("test change done");

    prog <= 1'b1;
    repeat (10) @(posedge sys_clk);
    rchk(`CDBA_OFS_STATUS, 32'h0000_1000, 32'h0000_1000, "program flag");
    far.mem[3] <= 16'h1111;
    repeat (100) @(posedge sys_clk);
    check({16'h0000, n_items}, 32'h0000_0001, "program hold");
    prog <= 1'b0;
    wait_marks(2, 300);
    check(last_item & 32'h0000_FFFF, 32'h0000_1111, "resume");
    $display("test program done");

    bus(1'b1, `CDBA_OFS_DELIVERY, 32'h0000_0064, rd);
    for (int i = 0; i < 13; i++) begin
      bus(1'b1, `CDBA_OFS_BLK_CFG, 32'h8000_3748 + 32'(i), rd);
    end
    stall <= 1'b1;
    for (int i = 0; i < 13; i++) begin
      far.mem[8 + i] <= 16'h0100 + 16'(i);
    end
    repeat (40) @(posedge sys_clk);
    check({31'h0000_0000, item_valid}, 32'h0000_0001, "held while stalled");
    stall <= 1'b0;
    wait_marks(3, 900);
    check(last_mark, 32'h8000_0558, "full frame");
    check({16'h0000, n_items}, 32'h0000_000E, "full count");
    wait_marks(4, 2000);
    check(last_mark, 32'h8000_0072, "late frame");
    check({16'h0000, n_items}, 32'h0000_000F, "late count");
    check(last_item, 32'h5370_010C, "late block");
    rchk(`CDBA_OFS_STATUS, 32'h0000_0FFF, 32'h0000_0000, "timer cleared");
    $display("test full buffer done");

    // Fifteen blocks are configured; one interval expiry queues each once.
    bus(1'b1, `CDBA_OFS_INTERVAL, 32'h0000_0001, rd);
    for (int k = 0; k < 12000 && n_items < 16'd30; k++) begin
      @(posedge sys_clk);
    end
    bus(1'b1, `CDBA_OFS_INTERVAL, 32'h0000_0000, rd);
    repeat (100) @(posedge sys_clk);
    check({16'h0000, n_items}, 32'h0000_001E, "forced items");
    $display("test interval done");
    summarize();
  end
endmodule

`default_nettype wire
